// [hw/fbmon_defs.vh]
/*
 constants of the fieldbus sync and error monitor: error codes, classes,
 latched word bit positions and sync lock count.
 assumes the includer runs on one clock with a synchronous reset.
*/
// Operation
// - two cycles without sync raise class 2 sync-missing error, error bit 21
// - one sync missed then next sync mistimed raises class 2 error, bit 21
// - unsupported or too deviant cycle time raises class 2 error, bit 21
// - tolerance above a quarter of cycle time raises class 2 error, bit 21
// - invalid I/O configuration raises class 1 error bit 21 with register address
// - module faults raise class 2 errors bit 21; general module error is class 1
// - modbus link interruption reports class 2 error or class 0 warning, bit 5
// - wrong monitor object count raises class 0 warning, warning bit 5
// - unsupported modbus service raises class 0 warning, warning bit 5
`ifndef FBMON_DEFS_VH
`define FBMON_DEFS_VH

`define BIT_COMM 21
`define BIT_MODBUS 5

`define CLASS_0 2'h0
`define CLASS_1 2'h1
`define CLASS_2 2'h2

`define CODE_NONE 16'h0000
`define CODE_SERVICE 16'hb100
`define CODE_IO_CFG 16'hb101
`define CODE_MOD_GENERAL 16'hb102
`define CODE_MOD_CHANNEL 16'hb103
`define CODE_MOD_INTERNAL 16'hb104
`define CODE_MOD_IO_TIMEOUT 16'hb105
`define CODE_MOD_MAPPING 16'hb106
`define CODE_CYCLE_TIME 16'hb120
`define CODE_SYNC_MISSING 16'hb121
`define CODE_SYNC_WRONG 16'hb122
`define CODE_TOLERANCE 16'hb123
`define CODE_NOT_SYNC 16'hb124
`define CODE_PROTOCOL 16'hb200
`define CODE_LINK_ERR 16'hb201
`define CODE_LINK_WARN 16'hb202
`define CODE_MONITOR_COUNT 16'hb203

`define SYNC_LOCK_CYCLES 7'h78

`endif

// [hw/fieldbus_sync_error_monitor.v]
/*
 fieldbus sync and error monitor: watches the master sync pin against the
 configured cycle time, collects module and modbus fault pulses, latches them
 into error and warning words and reports one coded event per cycle.
 assumes fault pulses and configuration come from logic on clk_in; the sync
 pin is asynchronous. cycle time and tolerance are counted in clk_in cycles.
*/
`include "fbmon_defs.vh"

module fieldbus_sync_error_monitor #(
	parameter CW = 24,
	parameter [23:0] MIN_CYCLE = 24'h0000c8,
	parameter [23:0] MAX_CYCLE = 24'h30d400
) (
	// clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// sync pin and cyclic configuration
	input wire sync_pin_in,
	input wire sync_enable_in,
	input wire [CW-1:0] cfg_cycle_time_in,
	input wire [CW-1:0] cfg_tolerance_in,
	input wire op_mode_activate_in,
	// configuration and module fault pulses
	input wire io_cfg_invalid_in,
	input wire [15:0] io_cfg_addr_in,
	input wire mod_general_in,
	input wire mod_channel_closed_in,
	input wire mod_internal_comm_in,
	input wire mod_io_timeout_in,
	input wire mod_io_mapping_in,
	// modbus pulses and link report mode
	input wire modbus_link_lost_in,
	input wire link_lost_is_error_in,
	input wire modbus_monitor_count_in,
	input wire modbus_service_in,
	input wire modbus_protocol_in,
	// clear masks
	input wire [31:0] clear_errors_in,
	input wire [31:0] clear_warnings_in,
	// latched words and event report
	output reg [31:0] latched_error_signals_out,
	output reg [31:0] latched_warnings_out,
	output reg event_valid_out,
	output reg [15:0] event_code_out,
	output reg [1:0] event_class_out,
	output reg [15:0] event_info_out,
	output reg sync_locked_out
);

	reg sync_meta_reg;
	reg sync_s_reg;
	reg sync_d_reg;
	reg enable_d_reg;
	reg seen_reg;
	reg missed_reg;
	reg [CW:0] count_reg;
	reg [6:0] good_reg;

	wire sync_rise;
	wire start;
	wire [CW:0] cfg_ext;
	wire [CW:0] tol_ext;
	wire [CW:0] twice;
	wire [CW:0] late_limit;
	wire [CW:0] diff;
	wire [CW+2:0] tol_x4;
	wire deviant;
	wire ev_missing;
	wire ev_wrong;
	wire ev_cycle;
	wire ev_tol;
	wire ev_not_sync;

	assign sync_rise = sync_s_reg & ~sync_d_reg;
	assign start = sync_enable_in & ~enable_d_reg;
	assign cfg_ext = {1'b0, cfg_cycle_time_in};
	assign tol_ext = {1'b0, cfg_tolerance_in};
	assign twice = {cfg_cycle_time_in, 1'b0};
	assign late_limit = cfg_ext + tol_ext;
	assign diff = (count_reg > cfg_ext) ? (count_reg - cfg_ext) : (cfg_ext - count_reg);
	assign deviant = diff > tol_ext;
	assign tol_x4 = {tol_ext, 2'b00};
	assign ev_missing = sync_enable_in & ~sync_rise &
		(count_reg + {{CW{1'b0}}, 1'b1} >= twice);
	assign ev_wrong = sync_enable_in & sync_rise & seen_reg & deviant & missed_reg;
	assign ev_cycle = (start & ((cfg_cycle_time_in < MIN_CYCLE[CW-1:0]) |
		(cfg_cycle_time_in > MAX_CYCLE[CW-1:0]))) |
		(sync_enable_in & sync_rise & seen_reg & deviant & ~missed_reg);
	assign ev_tol = start & (tol_x4 > {2'b00, cfg_ext});
	// judged on the reported lock so the warning and the lock output agree
	assign ev_not_sync = op_mode_activate_in & ~sync_locked_out;

	// sync pin synchroniser
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync_meta_reg <= 1'b0;
			sync_s_reg <= 1'b0;
		end else begin
			sync_meta_reg <= sync_pin_in;
			sync_s_reg <= sync_meta_reg;
		end
	end

	// cycle measurement and lock counting
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync_d_reg <= 1'b0;
			enable_d_reg <= 1'b0;
			seen_reg <= 1'b0;
			missed_reg <= 1'b0;
			count_reg <= {(CW+1){1'b0}};
			good_reg <= 7'h00;
		end else begin
			sync_d_reg <= sync_s_reg;
			enable_d_reg <= sync_enable_in;
			if (!sync_enable_in) begin
				seen_reg <= 1'b0;
				missed_reg <= 1'b0;
				count_reg <= {(CW+1){1'b0}};
				good_reg <= 7'h00;
			end else if (sync_rise) begin
				seen_reg <= 1'b1;
				missed_reg <= 1'b0;
				count_reg <= {{CW{1'b0}}, 1'b1};
				if (seen_reg && deviant) begin
					good_reg <= 7'h00;
				end else if (seen_reg && good_reg < `SYNC_LOCK_CYCLES) begin
					good_reg <= good_reg + 7'h01;
				end
			end else if (ev_missing) begin
				missed_reg <= 1'b0;
				count_reg <= {(CW+1){1'b0}};
				good_reg <= 7'h00;
			end else begin
				count_reg <= count_reg + {{CW{1'b0}}, 1'b1};
				if (count_reg > late_limit) begin
					missed_reg <= 1'b1;
				end
			end
		end
	end

	// event collection
	reg [31:0] err_set;
	reg [31:0] warn_set;
	reg ev_valid;
	reg [15:0] ev_code;
	reg [1:0] ev_class;
	reg [15:0] ev_info;
	wire link_err;
	wire link_warn;
	wire comm_err;
	wire modbus_warn;

	assign link_err = modbus_link_lost_in & link_lost_is_error_in;
	assign link_warn = modbus_link_lost_in & ~link_lost_is_error_in;
	assign comm_err = ev_missing | ev_wrong | ev_cycle | ev_tol | io_cfg_invalid_in |
		mod_general_in | mod_channel_closed_in | mod_internal_comm_in |
		mod_io_timeout_in | mod_io_mapping_in;
	assign modbus_warn = link_warn | modbus_monitor_count_in | modbus_service_in |
		modbus_protocol_in;

	always @* begin
		err_set = 32'h00000000;
		warn_set = 32'h00000000;
		err_set[`BIT_COMM] = comm_err;
		err_set[`BIT_MODBUS] = link_err;
		warn_set[`BIT_COMM] = ev_not_sync;
		warn_set[`BIT_MODBUS] = modbus_warn;
		ev_valid = 1'b1;
		ev_info = 16'h0000;
		ev_code = `CODE_NONE;
		ev_class = `CLASS_0;
		if (ev_missing) begin
			ev_code = `CODE_SYNC_MISSING;
			ev_class = `CLASS_2;
		end else if (ev_wrong) begin
			ev_code = `CODE_SYNC_WRONG;
			ev_class = `CLASS_2;
		end else if (ev_cycle) begin
			ev_code = `CODE_CYCLE_TIME;
			ev_class = `CLASS_2;
		end else if (ev_tol) begin
			ev_code = `CODE_TOLERANCE;
			ev_class = `CLASS_2;
		end else if (mod_channel_closed_in) begin
			ev_code = `CODE_MOD_CHANNEL;
			ev_class = `CLASS_2;
		end else if (mod_internal_comm_in) begin
			ev_code = `CODE_MOD_INTERNAL;
			ev_class = `CLASS_2;
		end else if (mod_io_timeout_in) begin
			ev_code = `CODE_MOD_IO_TIMEOUT;
			ev_class = `CLASS_2;
		end else if (mod_io_mapping_in) begin
			ev_code = `CODE_MOD_MAPPING;
			ev_class = `CLASS_2;
		end else if (link_err) begin
			ev_code = `CODE_LINK_ERR;
			ev_class = `CLASS_2;
		end else if (io_cfg_invalid_in) begin
			ev_code = `CODE_IO_CFG;
			ev_class = `CLASS_1;
			ev_info = io_cfg_addr_in;
		end else if (mod_general_in) begin
			ev_code = `CODE_MOD_GENERAL;
			ev_class = `CLASS_1;
		end else if (ev_not_sync) begin
			ev_code = `CODE_NOT_SYNC;
		end else if (link_warn) begin
			ev_code = `CODE_LINK_WARN;
		end else if (modbus_monitor_count_in) begin
			ev_code = `CODE_MONITOR_COUNT;
		end else if (modbus_service_in) begin
			ev_code = `CODE_SERVICE;
		end else if (modbus_protocol_in) begin
			ev_code = `CODE_PROTOCOL;
		end else begin
			ev_valid = 1'b0;
		end
	end

	// latched words: a set in the clearing cycle wins
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			latched_error_signals_out <= 32'h00000000;
			latched_warnings_out <= 32'h00000000;
			event_valid_out <= 1'b0;
			event_code_out <= `CODE_NONE;
			event_class_out <= `CLASS_0;
			event_info_out <= 16'h0000;
			sync_locked_out <= 1'b0;
		end else begin
			latched_error_signals_out <= (latched_error_signals_out & ~clear_errors_in) |
				err_set;
			latched_warnings_out <= (latched_warnings_out & ~clear_warnings_in) |
				warn_set;
			event_valid_out <= ev_valid;
			event_code_out <= ev_code;
			event_class_out <= ev_class;
			event_info_out <= ev_info;
			sync_locked_out <= sync_enable_in & (good_reg >= `SYNC_LOCK_CYCLES);
		end
	end

endmodule

// [tb/fbmon_master_model.sv]
/* master controller model: one sync pulse per period while running.
 assumes the monitor clock; the pin stays low while stopped. */
module fbmon_master (
	input wire logic clk_in,
	input wire logic run_in,
	input wire logic [23:0] period_in,
	output logic sync_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] cnt_reg = 24'h0;
	initial sync_out = 1'b0;
	always @(posedge clk_in) begin
		cnt_reg <= (!run_in || cnt_reg + 24'h1 >= period_in) ? 24'h0 : cnt_reg + 24'h1;
		sync_out <= run_in && cnt_reg == 24'h0;
	end
endmodule

// [tb/fieldbus_sync_error_monitor_chk.sv]
/* checker bound to the monitor top.
 assumes one clock and a synchronous active-low reset. */
`include "fbmon_defs.vh"
module fbmon_chk (
	input wire logic clk_in, rst_n_in, op_mode_activate_in, io_cfg_invalid_in,
	input wire logic mod_io_timeout_in, modbus_link_lost_in, link_lost_is_error_in,
	input wire logic modbus_service_in, sync_locked_out, event_valid_out,
	input wire logic [31:0] clear_errors_in, latched_error_signals_out, latched_warnings_out,
	input wire logic [15:0] event_code_out,
	input wire logic [1:0] event_class_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_cfg_err: assert property (
		io_cfg_invalid_in |=> latched_error_signals_out[21]) else $error("cfg fault lost");
	a_timeout_err: assert property (
		mod_io_timeout_in |=> event_valid_out && latched_error_signals_out[21])
		else $error("timeout fault lost");
	a_link_err: assert property (
		modbus_link_lost_in && link_lost_is_error_in |=> latched_error_signals_out[5])
		else $error("link error lost");
	a_link_warn: assert property (
		modbus_link_lost_in && !link_lost_is_error_in |=> latched_warnings_out[5])
		else $error("link warning lost");
	a_service_warn: assert property (
		modbus_service_in |=> latched_warnings_out[5]) else $error("service warning lost");
	a_notsync_warn: assert property (
		op_mode_activate_in && !sync_locked_out |=> latched_warnings_out[21])
		else $error("not-sync warning lost");
	a_miss_err: assert property (
		event_valid_out && event_code_out == `CODE_SYNC_MISSING |->
		event_class_out == `CLASS_2 && latched_error_signals_out[21]) else $error("missing bad");
	a_err_hold: assert property (
		latched_error_signals_out[21] && !clear_errors_in[21] |=> latched_error_signals_out[21])
		else $error("error bit dropped");
	c_miss: cover property (event_valid_out && event_code_out == `CODE_SYNC_MISSING);
	c_wrong: cover property (event_valid_out && event_code_out == `CODE_SYNC_WRONG);
	c_lock: cover property ($rose(sync_locked_out));
endmodule
bind fieldbus_sync_error_monitor fbmon_chk i_chk (.*);

// [tb/fieldbus_sync_error_monitor_tb.sv]
/* testbench of the monitor: fault pulses, then sync checks with the master model.
 assumes the design and its checker are compiled beforehand. */
`include "fbmon_defs.vh"
module fieldbus_sync_error_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 0, rst_n = 0, en = 0, opm = 0, lk = 0, run = 0, sync;
	logic [9:0] p = 10'h0;
	logic [15:0] addr = 16'h0;
	logic [23:0] cyc = 24'h14, tol = 24'h5, per = 24'h14;
	logic [31:0] ce = 32'h0, cw = 32'h0, w, le, lw;
	logic ev, lock;
	logic [15:0] code, info;
	logic [1:0] cls;
	int err_total = 0, comparisons = 0, seed = 89, cyc_n = 0, b;
	logic [15:0] cd [11] = '{16'hb101, 16'hb102, 16'hb103, 16'hb104, 16'hb105, 16'hb106,
		16'hb201, 16'hb202, 16'hb203, 16'hb100, 16'hb200};
	initial forever #2.5 clk_in = ~clk_in;
	fbmon_master i_master (.clk_in(clk_in), .run_in(run), .period_in(per), .sync_out(sync));
	fieldbus_sync_error_monitor #(.MIN_CYCLE(24'h10)) i_dut (
		.clk_in(clk_in), .rst_n_in(rst_n), .sync_pin_in(sync), .sync_enable_in(en),
		.cfg_cycle_time_in(cyc), .cfg_tolerance_in(tol), .op_mode_activate_in(opm),
		.io_cfg_invalid_in(p[0]), .io_cfg_addr_in(addr), .mod_general_in(p[1]),
		.mod_channel_closed_in(p[2]), .mod_internal_comm_in(p[3]), .mod_io_timeout_in(p[4]),
		.mod_io_mapping_in(p[5]), .modbus_link_lost_in(p[6]), .link_lost_is_error_in(lk),
		.modbus_monitor_count_in(p[7]), .modbus_service_in(p[8]), .modbus_protocol_in(p[9]),
		.clear_errors_in(ce), .clear_warnings_in(cw), .latched_error_signals_out(le),
		.latched_warnings_out(lw), .event_valid_out(ev), .event_code_out(code),
		.event_class_out(cls), .event_info_out(info), .sync_locked_out(lock));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	task summarize;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wait_ev(input logic [15:0] c, input int lim);
		for (int i = 0; i < lim && !(ev === 1'b1 && code === c); i++) @(posedge clk_in) #1;
		chk("code", code, c);
		chk("class", cls, `CLASS_2);
		$display("sync test %h done", c);
	endtask
	always @(posedge clk_in) if (++cyc_n == 20000) begin
		err_total++;
		summarize;
	end
	initial begin
		repeat (16) @(posedge clk_in);
		rst_n <= 1;
		for (int k = 0; k < 11; k++) begin
			@(posedge clk_in);
			repeat ($random(seed) & 3) @(posedge clk_in);
			p <= 10'h1 << (k < 7 ? k : k - 1);
			lk <= (k == 6);
			addr <= $random(seed);
			@(posedge clk_in);
			p <= 10'h0;
			#1 chk("valid", ev, 1);
			chk("code", code, cd[k]);
			chk("class", cls, k < 2 ? 1 : k < 7 ? 2 : 0);
			if (k == 0) chk("info", info, addr);
			b = k < 6 ? 21 : 5;
			@(posedge clk_in) #1 w = k < 7 ? le : lw;
			chk("held", w[b], 1);
			@(posedge clk_in);
			if (k < 7) ce <= 32'h1 << b;
			else cw <= 32'h1 << b;
			@(posedge clk_in);
			{ce, cw} <= 64'h0;
			#1 w = k < 7 ? le : lw;
			chk("cleared", w[b], 0);
			$display("fault %0d done", k);
		end
		@(posedge clk_in);
		cyc <= 24'h8;
		en <= 1;
		wait_ev(`CODE_CYCLE_TIME, 8);
		@(posedge clk_in) en <= 0;
		{cyc, tol} <= {24'h14, 24'h6};
		@(posedge clk_in) en <= 1;
		wait_ev(`CODE_TOLERANCE, 8);
		@(posedge clk_in) {en, tol, run} <= {1'b0, 24'h5, 1'b1};
		@(posedge clk_in) en <= 1;
		repeat (5) @(posedge clk_in);
		opm <= 1;
		@(posedge clk_in) opm <= 0;
		#1 chk("early", lw[21], 1);
		@(posedge clk_in) cw <= 32'h200000;
		repeat (2600) if (lock !== 1'b1) @(posedge clk_in);
		chk("locked", lock, 1);
		@(posedge clk_in) {cw, opm} <= {32'h0, 1'b1};
		@(posedge clk_in) opm <= 0;
		#1 chk("in step", lw[21], 0);
		@(posedge clk_in) per <= 24'h0e;
		wait_ev(`CODE_CYCLE_TIME, 60);
		@(posedge clk_in) per <= 24'h1e;
		wait_ev(`CODE_SYNC_WRONG, 100);
		@(posedge clk_in) {run, ce} <= {1'b0, 32'h200000};
		repeat (6) @(posedge clk_in);
		ce <= 32'h0;
		#1 chk("sync clr", le[21], 0);
		wait_ev(`CODE_SYNC_MISSING, 60);
		chk("sync err", le[21], 1);
		$display("sync checks done");
		summarize;
	end
endmodule
